// [hw/swi_flag_pkg.sv]
// constants for the single-wire flag protocol block
// assumes a token decoder upstream and one 125 MHz system clock
package swi_flag_pkg;
  localparam logic [7:0] FLAG_SLEEP    = 8'hCC;
  localparam logic [7:0] FLAG_IDLE     = 8'hBB;
  localparam logic [7:0] FLAG_COMMAND  = 8'h77;
  localparam logic [7:0] FLAG_TRANSMIT = 8'h88;
  localparam logic [7:0] STATUS_WAKE   = 8'h11;
  localparam logic [7:0] STATUS_OK     = 8'h00;
  localparam logic [7:0] STATUS_ERROR  = 8'h0F;
  localparam int CLK_MHZ          = 125;
  localparam int TIMEOUT_US       = 13;
  localparam int TURNAROUND_US    = 64;
  localparam int TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;
  localparam int TURNAROUND_CYC   = TURNAROUND_US * CLK_MHZ;
  localparam int COUNT_W          = 16;
  localparam int BUF_DEPTH        = 16;
  localparam int IDX_W            = 4;
  typedef enum logic [2:0] {
    ST_SLEEP, ST_IDLE, ST_AWAKE, ST_RECEIVE, ST_BUSY, ST_TURN, ST_SEND
  } link_state_t;
endpackage : swi_flag_pkg

// [hw/swi_flag_link.sv]
// link-layer flag control of a single-wire authentication device
// assumes a bit-token decoder and encoder outside; executor reports done
`timescale 1ns/1ps
`default_nettype none
module swi_flag_link #(
  parameter int TIMEOUT_CYC    = swi_flag_pkg::TIMEOUT_CYC,
  parameter int TURNAROUND_CYC = swi_flag_pkg::TURNAROUND_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // decoded tokens from the wire
  input  wire logic       wake_i,
  input  wire logic       tok_start_i,
  input  wire logic       tok_valid_i,
  input  wire logic       tok_bit_i,
  input  wire logic       tok_bad_i,
  // command executor
  input  wire logic [7:0] block_len_i,
  input  wire logic       exec_done_i,
  input  wire logic       exec_err_i,
  input  wire logic       pause_i,
  input  wire logic [7:0] pause_sel_i,
  input  wire logic       extra_update_command_i,
  input  wire logic [7:0] new_sel_i,
  input  wire logic [7:0] selector_policy_byte_i,
  input  wire logic       cfg_locked_i,
  // response bit stream
  input  wire logic       tx_ready_i,
  output logic            tx_valid_o,
  output logic            tx_bit_o,
  // status toward the rest of the device
  output logic            sleep_o,
  output logic            idle_o,
  output logic            busy_o,
  output logic            exec_start_o,
  output logic            cmd_we_o,
  output logic [3:0]      cmd_addr_o,
  output logic [7:0]      cmd_data_o,
  output logic            key_clear_o,
  output logic            update_err_o,
  output logic [7:0]      selector_o
);
  swi_flag_pkg::link_state_t state;
  logic [7:0]  shreg;
  logic [2:0]  bitcnt;
  logic [7:0]  bytecnt;
  logic [15:0] tmo;
  logic        tmo_arm;
  logic [15:0] turn;
  logic [7:0]  resp;
  logic        results_valid;
  logic        sel_used;
  logic        sel_locked_zero;
  logic        byte_done;
  logic [7:0]  byte_val;
  logic        listen;
  logic        tmo_fire;
  logic        byte_done_last;
  logic [2:0]  bitcnt_tx;
  logic        tx_xfer;

  // ---------------------------------------------------------------
  // bit assembly
  // ---------------------------------------------------------------
  // tokens arrive lsb first; a byte is complete on its eighth token
  assign listen    = (state == swi_flag_pkg::ST_AWAKE) || (state == swi_flag_pkg::ST_RECEIVE);
  assign byte_done = listen && tok_valid_i && (bitcnt == 3'h7);
  assign byte_val  = {tok_bit_i, shreg[7:1]};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg  <= 8'h00;
      bitcnt <= 3'h0;
    end else if (!listen) begin
      bitcnt <= 3'h0;
    end else if (tok_valid_i) begin
      shreg  <= byte_val;
      bitcnt <= bitcnt + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // link state
  // ---------------------------------------------------------------
  assign tmo_fire = tmo_arm && (tmo == 16'(TIMEOUT_CYC - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= swi_flag_pkg::ST_SLEEP;
      bytecnt <= 8'h00;
    end else begin
      case (state)
        swi_flag_pkg::ST_SLEEP, swi_flag_pkg::ST_IDLE: begin
          if (wake_i) state <= swi_flag_pkg::ST_AWAKE;
        end
        swi_flag_pkg::ST_AWAKE: begin
          if (tmo_fire) begin
            state <= swi_flag_pkg::ST_SLEEP;
          end else if (byte_done) begin
            if (byte_val == swi_flag_pkg::FLAG_SLEEP) state <= swi_flag_pkg::ST_SLEEP;
            else if (byte_val == swi_flag_pkg::FLAG_IDLE) state <= swi_flag_pkg::ST_IDLE;
            else if (byte_val == swi_flag_pkg::FLAG_COMMAND) begin
              state   <= swi_flag_pkg::ST_RECEIVE;
              bytecnt <= 8'h00;
            end else if (byte_val == swi_flag_pkg::FLAG_TRANSMIT) begin
              state <= swi_flag_pkg::ST_TURN;
            end
          end
        end
        swi_flag_pkg::ST_RECEIVE: begin
          if (tmo_fire) state <= swi_flag_pkg::ST_SLEEP;
          else if (byte_done && (bytecnt + 8'h1 >= block_len_i)) state <= swi_flag_pkg::ST_BUSY;
          if (byte_done) bytecnt <= bytecnt + 8'h1;
        end
        swi_flag_pkg::ST_BUSY: begin
          if (exec_done_i) begin
            // a pause with a foreign selector idles this device
            if (pause_i && (pause_sel_i != selector_o)) state <= swi_flag_pkg::ST_IDLE;
            else state <= swi_flag_pkg::ST_AWAKE;
          end
        end
        swi_flag_pkg::ST_TURN: begin
          if (turn == 16'(TURNAROUND_CYC - 1)) state <= swi_flag_pkg::ST_SEND;
        end
        swi_flag_pkg::ST_SEND: begin
          if (tx_xfer && bitcnt_tx == 3'h7) state <= swi_flag_pkg::ST_AWAKE;
        end
        default: state <= swi_flag_pkg::ST_SLEEP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // inter-bit timeout and turnaround counters
  // ---------------------------------------------------------------
  // the timeout covers a token in flight or an open command block, never execution
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_arm <= 1'b0;
      tmo     <= 16'h0000;
    end else if (!listen || tok_valid_i) begin
      tmo_arm <= listen && (state == swi_flag_pkg::ST_RECEIVE || byte_done &&
                 byte_val == swi_flag_pkg::FLAG_COMMAND) && !byte_done_last;
      tmo     <= 16'h0000;
    end else if (tok_start_i || tok_bad_i) begin
      tmo_arm <= 1'b1;
    end else if (tmo_arm) begin
      tmo <= tmo + 16'h0001;
    end
  end

  assign byte_done_last = (state == swi_flag_pkg::ST_RECEIVE) && byte_done &&
                          (bytecnt + 8'h1 >= block_len_i);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) turn <= 16'h0000;
    else if (state == swi_flag_pkg::ST_TURN) turn <= turn + 16'h0001;
    else turn <= 16'h0000;
  end

  // ---------------------------------------------------------------
  // response byte and bit serialiser
  // ---------------------------------------------------------------
  // a bit counts as sent only when shown and taken, so stalls cannot skip one
  assign tx_xfer = tx_valid_o && tx_ready_i;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp          <= swi_flag_pkg::STATUS_WAKE;
      results_valid <= 1'b0;
    end else if (state == swi_flag_pkg::ST_SLEEP) begin
      resp          <= swi_flag_pkg::STATUS_WAKE;
      results_valid <= 1'b0;
    end else if (state == swi_flag_pkg::ST_BUSY && exec_done_i) begin
      resp          <= exec_err_i || update_err_o ? swi_flag_pkg::STATUS_ERROR
                                                  : swi_flag_pkg::STATUS_OK;
      results_valid <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_bit_o   <= 1'b0;
      bitcnt_tx  <= 3'h0;
    end else if (state == swi_flag_pkg::ST_SEND) begin
      tx_valid_o <= !(tx_xfer && bitcnt_tx == 3'h7);
      if (tx_xfer) begin
        bitcnt_tx <= bitcnt_tx + 3'h1;
        tx_bit_o  <= resp[bitcnt_tx + 3'h1];
      end else begin
        tx_bit_o  <= resp[bitcnt_tx];
      end
    end else begin
      tx_valid_o <= 1'b0;
      tx_bit_o   <= 1'b0;
      bitcnt_tx  <= 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // command buffer write port and status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_we_o     <= 1'b0;
      cmd_addr_o   <= 4'h0;
      cmd_data_o   <= 8'h00;
      exec_start_o <= 1'b0;
    end else begin
      cmd_we_o     <= (state == swi_flag_pkg::ST_RECEIVE) && byte_done;
      cmd_addr_o   <= bytecnt[3:0];
      cmd_data_o   <= byte_val;
      exec_start_o <= byte_done_last && !tmo_fire;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_o     <= 1'b1;
      idle_o      <= 1'b0;
      busy_o      <= 1'b0;
      key_clear_o <= 1'b1;
    end else begin
      sleep_o     <= (state == swi_flag_pkg::ST_SLEEP);
      idle_o      <= (state == swi_flag_pkg::ST_IDLE);
      busy_o      <= (state == swi_flag_pkg::ST_BUSY);
      key_clear_o <= (state == swi_flag_pkg::ST_SLEEP);
    end
  end

  // ---------------------------------------------------------------
  // selector byte update policy
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      selector_o      <= 8'h00;
      sel_used        <= 1'b0;
      sel_locked_zero <= 1'b1;
      update_err_o    <= 1'b0;
    end else begin
      if (!cfg_locked_i) sel_locked_zero <= (selector_o == 8'h00);
      update_err_o <= 1'b0;
      if (extra_update_command_i) begin
        if (selector_policy_byte_i == 8'h00 || !cfg_locked_i) begin
          selector_o <= new_sel_i;
        end else if (sel_locked_zero && !sel_used && new_sel_i != 8'h00) begin
          selector_o <= new_sel_i;
          sel_used   <= 1'b1;
        end else begin
          update_err_o <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // a flag takes effect in the state first and on the status pins one edge later
  sequence seq_sleep_out;
    state == swi_flag_pkg::ST_SLEEP ##1 sleep_o;
  endsequence : seq_sleep_out
  sequence seq_idle_out;
    state == swi_flag_pkg::ST_IDLE ##1 idle_o && !key_clear_o;
  endsequence : seq_idle_out
  chk_sleep_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_AWAKE && byte_done && byte_val == swi_flag_pkg::FLAG_SLEEP
     && !tmo_fire) |=> seq_sleep_out)
    else $error("sleep flag did not sleep");
  chk_idle_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_AWAKE && byte_done && byte_val == swi_flag_pkg::FLAG_IDLE
     && !tmo_fire) |=> seq_idle_out)
    else $error("idle flag did not idle");
  chk_cmd_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_RECEIVE && byte_done) |=> cmd_we_o && cmd_data_o == $past(byte_val))
    else $error("command byte not stored");
  chk_busy_deaf: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_BUSY && !exec_done_i) |=> state == swi_flag_pkg::ST_BUSY)
    else $error("busy state left without done");
  chk_wake_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_SLEEP && wake_i) |=> ##1 !sleep_o)
    else $error("wake ignored");
  // helper count of turnaround cycles keeps the bound a cheap compare
  logic [15:0] chk_turn_cnt;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) chk_turn_cnt <= 16'h0000;
    else if (state == swi_flag_pkg::ST_TURN) chk_turn_cnt <= chk_turn_cnt + 16'h0001;
    else chk_turn_cnt <= 16'h0000;
  end
  chk_turn_time: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_TURN) |-> chk_turn_cnt < 16'(TURNAROUND_CYC))
    else $error("no answer within turnaround");
  chk_fixed_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (extra_update_command_i && cfg_locked_i && selector_policy_byte_i != 8'h00
     && !sel_locked_zero) |=> update_err_o && $stable(selector_o))
    else $error("fixed selector changed");
  chk_wake_status: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_SLEEP) |=> resp == swi_flag_pkg::STATUS_WAKE)
    else $error("wake status wrong");
  // the encoder may stall; a held bit must not change under it
  chk_tx_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_bit_o))
    else $error("response bit dropped before taken");
  chk_timeout_sleep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (listen && tmo_fire) |=> state == swi_flag_pkg::ST_SLEEP)
    else $error("timeout did not sleep");
  chk_block_armed: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_AWAKE && byte_done && byte_val == swi_flag_pkg::FLAG_COMMAND
     && !tmo_fire) |=> state == swi_flag_pkg::ST_RECEIVE && tmo_arm)
    else $error("command flag did not arm timeout");
  chk_busy_disarm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_BUSY) |-> !tmo_arm)
    else $error("timeout armed during execution");
  chk_pause_match: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_BUSY && exec_done_i && (!pause_i || pause_sel_i == selector_o))
    |=> state == swi_flag_pkg::ST_AWAKE)
    else $error("matching device did not stay awake");
  chk_idle_deaf: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_IDLE && !wake_i) |=> state == swi_flag_pkg::ST_IDLE)
    else $error("idle left without wake");
  chk_wake_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_IDLE && wake_i) |=> state == swi_flag_pkg::ST_AWAKE)
    else $error("wake from idle ignored");
  // policy checks see the selector one edge after the command
  chk_one_update: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (extra_update_command_i && cfg_locked_i && selector_policy_byte_i != 8'h00 && sel_used)
    |=> update_err_o && $stable(selector_o))
    else $error("second field update accepted");
  chk_sel_free: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (extra_update_command_i && selector_policy_byte_i == 8'h00) |=> selector_o == $past(new_sel_i))
    else $error("free selector not written");
  chk_turn_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_TURN && turn == 16'(TURNAROUND_CYC - 1)) |=> state == swi_flag_pkg::ST_SEND ##1 tx_valid_o)
    else $error("response not started after turnaround");
  chk_sleep_wipe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_SLEEP) |=> !results_valid)
    else $error("results kept through sleep");
  chk_results_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_SEND) |-> results_valid || resp == swi_flag_pkg::STATUS_WAKE)
    else $error("response is neither status nor result");
  chk_cmd_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (byte_done_last && !tmo_fire) |=> exec_start_o ##1 busy_o)
    else $error("full block did not start execution");
  chk_cmd_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == swi_flag_pkg::ST_RECEIVE && byte_done) |=> cmd_addr_o == $past(bytecnt[3:0]))
    else $error("command byte at wrong address");
endmodule : swi_flag_link
`default_nettype wire

// [dv/swi_host_model.sv]
// host model: sends decoded tokens, takes the response bit stream
// assumes one free-running clock; outputs change on its falling edge
`timescale 1ns/1ps
`default_nettype none
module swi_host_model (
  // clock
  input  wire logic sys_clk_i,
  // tokens toward the device
  output var logic  wake_o,
  output var logic  tok_start_o,
  output var logic  tok_valid_o,
  output var logic  tok_bit_o,
  output var logic  tok_bad_o,
  // response sink
  output var logic  tx_ready_o
);
  integer seed = 75;
  initial {wake_o, tok_start_o, tok_valid_o, tok_bit_o, tok_bad_o, tx_ready_o} = '0;
  // random stalls on about one cycle in three make the device hold some response bits
  always @(negedge sys_clk_i) tx_ready_o = $random(seed) % 3 != 0;
  task automatic pulse_wake();
    @(negedge sys_clk_i) wake_o = 1'b1;
    @(negedge sys_clk_i) wake_o = 1'b0;
  endtask : pulse_wake
  // leading edge, then the bit (or an over-long low pulse) after a random gap
  task automatic token(input logic b, input logic bad);
    @(negedge sys_clk_i) tok_start_o = 1'b1;
    @(negedge sys_clk_i) tok_start_o = 1'b0;
    repeat (1 + {$random(seed)} % 4) @(negedge sys_clk_i);
    tok_bad_o = bad;
    tok_valid_o = !bad;
    tok_bit_o = b;
    // the bit line flips once released so a stale value cannot pass
    @(negedge sys_clk_i) {tok_valid_o, tok_bad_o, tok_bit_o} = {2'b00, !b};
  endtask : token
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      token(v[i], 1'b0);
    end
  endtask : send_byte
endmodule : swi_host_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the flag-level link control
// assumes the host model for tokens; the bench plays the executor
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
`define AWAIT(nm, s, v, lim) begin for (int i = 0; i < (lim) && (s) !== (v); i++) \
  @(negedge sys_clk); `CHECK(nm, v, s) end
module tb_top;
  localparam int TO = 20;
  localparam int TA = 10;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wake, tok_start, tok_valid, tok_bit, tok_bad, tx_ready;
  logic        exec_done = 1'b0, exec_err = 1'b0, pause = 1'b0, xupd = 1'b0, locked = 1'b0;
  logic [7:0]  block_len = 8'h00, pause_sel = 8'h00, new_sel = 8'h00, policy = 8'h00;
  logic        tx_valid, tx_bit, sleep, idle, busy, exec_start, cmd_we, key_clear, update_err;
  logic [3:0]  cmd_addr;
  logic [7:0]  cmd_data, selector, rx, e, d;
  logic [11:0] w;
  logic [7:0]  exp_q[$];
  logic [11:0] wr_q[$];
  int          nb = 0, n_err = 0, n_start = 0, n_mismatch = 0, num_checks = 0;
  always #4 sys_clk = ~sys_clk;
  swi_host_model u_host (.sys_clk_i(sys_clk), .wake_o(wake), .tok_start_o(tok_start),
    .tok_valid_o(tok_valid), .tok_bit_o(tok_bit), .tok_bad_o(tok_bad), .tx_ready_o(tx_ready));
  swi_flag_link #(.TIMEOUT_CYC(TO), .TURNAROUND_CYC(TA)) u_dut (.sys_clk_i(sys_clk),
    .rst_n_i(rst_n), .wake_i(wake), .tok_start_i(tok_start), .tok_valid_i(tok_valid),
    .tok_bit_i(tok_bit), .tok_bad_i(tok_bad), .block_len_i(block_len),
    .exec_done_i(exec_done), .exec_err_i(exec_err), .pause_i(pause), .pause_sel_i(pause_sel),
    .extra_update_command_i(xupd), .new_sel_i(new_sel), .selector_policy_byte_i(policy),
    .cfg_locked_i(locked), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_bit_o(tx_bit),
    .sleep_o(sleep), .idle_o(idle), .busy_o(busy), .exec_start_o(exec_start),
    .cmd_we_o(cmd_we), .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data),
    .key_clear_o(key_clear), .update_err_o(update_err), .selector_o(selector));
  // ----
  // monitor: rebuilds response bytes lsb first and matches buffer writes
  // ----
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      rx = {tx_bit, rx[7:1]};
      nb++;
      if (nb == 8) begin
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
        `CHECK("tx byte", e, rx)
        nb = 0;
      end
    end
    if (cmd_we === 1'b1) begin
      w = (wr_q.size() != 0) ? wr_q.pop_front() : 12'hXXX;
      `CHECK("cmd write", w, {cmd_addr, cmd_data})
    end
    if (update_err === 1'b1) n_err++;
    if (exec_start === 1'b1) n_start++;
  end
  task automatic transmit(input logic [7:0] ex);
    int n;
    exp_q.push_back(ex);
    u_host.send_byte(swi_flag_pkg::FLAG_TRANSMIT);
    for (n = 0; n < 300 && tx_valid !== 1'b1; n++) @(negedge sys_clk);
    `CHECK("turnaround", 1'b1, n >= TA - 2 && n <= TA + 3)
    for (n = 0; n < 400 && exp_q.size() != 0; n++) @(negedge sys_clk);
    `CHECK("response left", 0, exp_q.size())
  endtask : transmit
  task automatic quiet(input string nm);
    u_host.send_byte(swi_flag_pkg::FLAG_TRANSMIT);
    repeat (TO + 5) @(negedge sys_clk);
    `CHECK(nm, 1'b0, tx_valid)
  endtask : quiet
  // sends the command flag and the first n of len block bytes
  task automatic cmd(input logic [7:0] len, input int n);
    block_len = len;
    u_host.send_byte(swi_flag_pkg::FLAG_COMMAND);
    for (int a = 0; a < n; a++) begin
      d = 8'($random(u_host.seed));
      wr_q.push_back({a[3:0], d});
      u_host.send_byte(d);
    end
  endtask : cmd
  task automatic finish_exec(input logic err, input logic pz, input logic [7:0] sel);
    @(negedge sys_clk);
    {exec_done, exec_err, pause, pause_sel} = {1'b1, err, pz, sel};
    @(negedge sys_clk);
    {exec_done, exec_err, pause} = 3'b000;
  endtask : finish_exec
  task automatic upd(input logic [7:0] v, input logic [7:0] ex);
    @(negedge sys_clk);
    {xupd, new_sel} = {1'b1, v};
    @(negedge sys_clk);
    xupd = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHECK("selector", ex, selector)
  endtask : upd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200_000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    `CHECK("reset sleep", 1'b1, sleep)
    `CHECK("reset key", 1'b1, key_clear)
    rst_n = 1'b1;
    u_host.pulse_wake();
    `AWAIT("wake", sleep, 1'b0, 4)
    transmit(swi_flag_pkg::STATUS_WAKE);
    transmit(swi_flag_pkg::STATUS_WAKE);
    $display("test wake done");
    for (int k = 0; k < 2; k++) begin
      cmd(8'h03, 3);
      `AWAIT("busy", busy, 1'b1, 4)
      quiet("busy transmit");
      `CHECK("busy no timeout", 1'b0, sleep)
      finish_exec(k[0], 1'b0, 8'h00);
      `AWAIT("not busy", busy, 1'b0, 4)
      transmit(k[0] ? swi_flag_pkg::STATUS_ERROR : swi_flag_pkg::STATUS_OK);
    end
    $display("test command done");
    locked = 1'b1;
    upd(8'h5A, 8'h5A);
    upd(8'h00, 8'h00);
    {policy, locked} = {8'h01, 1'b0};
    @(negedge sys_clk) locked = 1'b1;
    upd(8'h3C, 8'h3C);
    upd(8'h77, 8'h3C);
    locked = 1'b0;
    @(negedge sys_clk) locked = 1'b1;
    upd(8'h11, 8'h3C);
    `CHECK("update errors", 2, n_err)
    $display("test selector done");
    cmd(8'h01, 1);
    finish_exec(1'b0, 1'b1, 8'h3D);
    `AWAIT("paused", idle, 1'b1, 4)
    quiet("idle transmit");
    u_host.pulse_wake();
    `AWAIT("woken", idle, 1'b0, 4)
    cmd(8'h01, 1);
    finish_exec(1'b0, 1'b1, 8'h3C);
    transmit(swi_flag_pkg::STATUS_OK);
    u_host.send_byte(swi_flag_pkg::FLAG_IDLE);
    `AWAIT("idle flag", idle, 1'b1, 4)
    `CHECK("idle keeps key", 1'b0, key_clear)
    $display("test pause done");
    u_host.pulse_wake();
    u_host.send_byte(swi_flag_pkg::FLAG_SLEEP);
    `AWAIT("sleep flag", sleep, 1'b1, 4)
    `CHECK("sleep clears key", 1'b1, key_clear)
    u_host.pulse_wake();
    transmit(swi_flag_pkg::STATUS_WAKE);
    u_host.token(1'b0, 1'b1);
    `CHECK("early sleep", 1'b0, sleep)
    `AWAIT("bad token", sleep, 1'b1, TO + 6)
    u_host.pulse_wake();
    cmd(8'h02, 1);
    `AWAIT("block timeout", sleep, 1'b1, TO + 6)
    `CHECK("exec starts", 4, n_start)
    $display("test sleep and timeout done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
